// [rtl/nvm_cmd_regs.sv]
// Register front end: pointer, operand, operation code and protected launch
`timescale 1ns/1ps
// Overview of operation
// - Three pointer bytes form one 24-bit location pointer driven to the memory engine.
// - Pointer bytes sit at offsets 0x00, 0x01 and 0x02, low to extended, all read and write.
// - Three operand bytes form one 24-bit data value carrying operand or result.
// - Operand bytes sit at offsets 0x04, 0x05 and 0x06, read and write, reset to zero.
// - The operation code at 0x0A holds seven bits; codes with bit 6 set are external only.
// - Writing one to bit 0 of the launch register at 0x0B starts the selected operation.
// - A launch write counts only inside a valid change protection unlock window.
// - Bits 7:1 of the launch register read zero and software writes zeros there.
// - A busy flag is set when a launched operation starts and clears when it completes.
module nvm_cmd_regs
   import nvm_regs_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                  I_CLK_SYS,
   input  wire logic                  I_RST_N,
   input  wire logic                  i_ce,
   // Register port
   input  wire logic [ADDR_W-1:0]     i_addr,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   input  wire logic [BYTE_W-1:0]     i_wdata,
   output logic      [BYTE_W-1:0]     o_rdata,
   // Change protection key seen by the core
   input  wire logic                  i_unlock_key,
   // Memory engine side
   output logic      [WORD_W-1:0]     o_location,
   output logic      [WORD_W-1:0]     o_operand,
   output logic      [CODE_W-1:0]     o_op_code,
   output logic                       o_launch,
   output logic                       o_busy,
   input  wire logic                  i_op_done,
   input  wire logic                  i_result_valid,
   input  wire logic [WORD_W-1:0]     i_result
);
   import nvm_regs_pkg::*;

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic       rst_meta_q;
   logic       rst_sync_q;
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // ---------------------------------------------------------------
   // Pointer and operand bytes
   // ---------------------------------------------------------------
   logic [BYTE_W-1:0] ptr_q [3];
   logic [BYTE_W-1:0] dat_q [3];
   localparam logic [ADDR_W-1:0] PTR_OFS [3] = '{OFS_PTR_LOW, OFS_PTR_MID, OFS_PTR_EXT};
   localparam logic [ADDR_W-1:0] DAT_OFS [3] = '{OFS_DATA_B0, OFS_DATA_B1, OFS_DATA_B2};

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_bytes
         always_ff @(posedge I_CLK_SYS or negedge rst_sync_q)
         begin
            if (!rst_sync_q)
               ptr_q[g] <= BYTE_RST;
            else if (i_ce && i_wr && hit(i_addr, PTR_OFS[g]))
               ptr_q[g] <= i_wdata;
         end
         // operand byte store
         // Result from the engine wins over a software write in the same cycle
         always_ff @(posedge I_CLK_SYS or negedge rst_sync_q)
         begin
            if (!rst_sync_q)
               dat_q[g] <= BYTE_RST;
            else if (i_ce && i_result_valid)
               dat_q[g] <= i_result[g*BYTE_W +: BYTE_W];
            else if (i_ce && i_wr && hit(i_addr, DAT_OFS[g]))
               dat_q[g] <= i_wdata;
         end
      end
   endgenerate

   assign o_location = {ptr_q[2], ptr_q[1], ptr_q[0]};
   assign o_operand  = {dat_q[2], dat_q[1], dat_q[0]};

   // ---------------------------------------------------------------
   // Operation code
   // ---------------------------------------------------------------
   logic [CODE_W-1:0] code_q;
   always_ff @(posedge I_CLK_SYS or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         code_q <= BYTE_RST[CODE_W-1:0];
      else if (i_ce && i_wr && hit(i_addr, OFS_OP_CODE))
         code_q <= i_wdata[CODE_W-1:0];
   end
   assign o_op_code = code_q;

   // ---------------------------------------------------------------
   // Protected launch
   // ---------------------------------------------------------------
   logic [2:0] unlock_cnt_q;
   logic       launch_q;
   logic       launch_req;

   always_ff @(posedge I_CLK_SYS or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         unlock_cnt_q <= 3'h0;
      else if (i_ce)
      begin
         if (i_unlock_key)
            unlock_cnt_q <= UNLOCK_CYCLES;
         else if (unlock_cnt_q != 3'h0)
            unlock_cnt_q <= unlock_cnt_q - 3'h1;
      end
   end

   // ignored without unlock
   // A launch while busy or while a pulse is pending is dropped: busy only rises
   // one edge after the pulse, so without the pending term the pulse could stretch
   assign launch_req = i_wr && hit(i_addr, OFS_LAUNCH) && i_wdata[LAUNCH_BIT]
                       && (unlock_cnt_q != 3'h0) && !o_busy && !launch_q;

   always_ff @(posedge I_CLK_SYS or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         launch_q <= 1'b0;
      else if (i_ce)
         launch_q <= launch_req;
   end
   assign o_launch = launch_q && i_ce;

   nvm_op_if op_bus ();
   assign op_bus.launch = o_launch;
   assign op_bus.done   = i_op_done;

   nvm_op_sequencer u_seq
   (
      .i_clk   (I_CLK_SYS),
      .i_rst_n (rst_sync_q),
      .i_ce    (i_ce),
      .op      (op_bus.seq)
   );

   assign o_busy = op_bus.busy;

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         o_rdata <= BYTE_RST;
      else if (i_ce && i_rd)
      begin
         case (i_addr)
            OFS_PTR_LOW: o_rdata <= ptr_q[0];
            OFS_PTR_MID: o_rdata <= ptr_q[1];
            OFS_PTR_EXT: o_rdata <= ptr_q[2];
            OFS_DATA_B0: o_rdata <= dat_q[0];
            OFS_DATA_B1: o_rdata <= dat_q[1];
            OFS_DATA_B2: o_rdata <= dat_q[2];
            OFS_OP_CODE: o_rdata <= {1'b0, code_q};
            OFS_LAUNCH:  o_rdata <= BYTE_RST;
            OFS_STATUS:
            begin
               o_rdata           <= BYTE_RST;
               o_rdata[BUSY_BIT] <= o_busy;
            end
            default:     o_rdata <= BYTE_RST;
         endcase
      end
   end
endmodule

// [inc/nvm_regs_pkg.sv]
// Register map, field layout and reset values of the nonvolatile command front end
package nvm_regs_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned WORD_W = 24;
   localparam int unsigned CODE_W = 7;

   localparam logic [ADDR_W-1:0] OFS_PTR_LOW  = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_PTR_MID  = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_PTR_EXT  = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_DATA_B0  = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_DATA_B1  = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_DATA_B2  = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_OP_CODE  = 4'hA;
   localparam logic [ADDR_W-1:0] OFS_LAUNCH   = 4'hB;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'hF;

   localparam logic [BYTE_W-1:0] BYTE_RST     = 8'h00;
   localparam int unsigned       LAUNCH_BIT   = 0;
   localparam int unsigned       BUSY_BIT     = 7;
   localparam int unsigned       EXT_CODE_BIT = 6;

   // Unlock window length in clock cycles after the key is seen
   localparam logic [2:0]        UNLOCK_CYCLES = 3'h4;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN  = 3'b100
   } launch_state_type;
endpackage

// [inc/nvm_op_if.sv]
// Launch and completion handshake between the register front end and its sequencer
`timescale 1ns/1ps
interface nvm_op_if;
   logic launch;
   logic busy;
   logic done;
   modport front (output launch, input busy);
   modport seq   (input launch, output busy, input done);
endinterface

// [rtl/nvm_op_sequencer.sv]
// Tracks one launched nonvolatile operation from start to completion
`timescale 1ns/1ps
module nvm_op_sequencer
   import nvm_regs_pkg::*;
(
   // Clock and reset
   input  wire logic  i_clk,
   input  wire logic  i_rst_n,
   input  wire logic  i_ce,
   // Operation handshake
   nvm_op_if.seq      op
);
   launch_state_type state_q;
   launch_state_type state_d;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (op.launch)
               state_d = ST_WAIT;
         ST_WAIT:
            state_d = ST_RUN;
         ST_RUN:
            if (op.done)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state_q <= ST_IDLE;
      else if (i_ce)
         state_q <= state_d;
   end

   assign op.busy = (state_q != ST_IDLE);
endmodule

// [tb/nvm_cmd_regs_sva.sv]
// Port-level assertions for the command front end
`timescale 1ns/1ps
module nvm_cmd_regs_sva
   import nvm_regs_pkg::*;
(
   // Inputs
   input wire logic              I_CLK_SYS,
   input wire logic              I_RST_N,
   input wire logic              i_ce,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [BYTE_W-1:0] i_wdata,
   input wire logic              i_op_done,
   // Outputs
   input wire logic [BYTE_W-1:0] o_rdata,
   input wire logic [WORD_W-1:0] o_location,
   input wire logic              o_launch,
   input wire logic              o_busy
);
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);
   a_launch_one_shot: assert property (o_launch |=> !o_launch)
      else $error("launch longer than one cycle");
   a_launch_cause: assert property (o_launch |-> $past(i_wr) && $past(i_wdata[LAUNCH_BIT])
      && $past(i_addr) == OFS_LAUNCH)
      else $error("launch without launch write");
   a_busy_follows: assert property (o_launch |=> o_busy)
      else $error("busy missing after launch");
   a_busy_holds: assert property (o_busy && !i_op_done |=> o_busy)
      else $error("busy dropped early");
   a_busy_clears: assert property (o_busy && $past(o_busy) && i_op_done && i_ce
      |=> !o_busy)
      else $error("busy stuck after done");
   a_code_top_zero: assert property (i_rd && i_ce && i_addr == OFS_OP_CODE
      |=> !o_rdata[BYTE_W-1])
      else $error("code bit 7 reads one");
   a_launch_reads_zero: assert property (i_rd && i_ce && i_addr == OFS_LAUNCH
      |=> o_rdata == BYTE_RST)
      else $error("launch register not zero");
   a_ptr_low_write: assert property (i_wr && i_ce && i_addr == OFS_PTR_LOW
      |=> o_location[7:0] == $past(i_wdata))
      else $error("pointer low byte not written");
endmodule
bind nvm_cmd_regs nvm_cmd_regs_sva i_sva (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
   .i_ce(i_ce), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
   .i_op_done(i_op_done), .o_rdata(o_rdata), .o_location(o_location),
   .o_launch(o_launch), .o_busy(o_busy));

// [tb/nvm_command_register_interface_bench.sv]
// Self-checking bench for the command front end
`timescale 1ns/1ps
module nvm_command_register_interface_bench;
   import nvm_regs_pkg::*;
   logic              I_CLK_SYS, I_RST_N, i_ce, i_wr, i_rd, i_unlock_key;
   logic              i_op_done, i_result_valid, o_launch, o_busy;
   logic [ADDR_W-1:0] i_addr;
   logic [BYTE_W-1:0] i_wdata, o_rdata;
   logic [WORD_W-1:0] i_result, o_location, o_operand, n;
   logic [CODE_W-1:0] o_op_code;
   logic [ADDR_W-1:0] ofs [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'hA, 4'hB, 4'hF, 4'h3};
   int                num_errors, num_checks;
   nvm_cmd_regs i_dut (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .i_ce(i_ce),
      .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
      .i_unlock_key(i_unlock_key), .o_location(o_location), .o_operand(o_operand),
      .o_op_code(o_op_code), .o_launch(o_launch), .o_busy(o_busy),
      .i_op_done(i_op_done), .i_result_valid(i_result_valid), .i_result(i_result));
   initial
   begin
      I_CLK_SYS = 1'b0;
      forever #12.5 I_CLK_SYS = ~I_CLK_SYS;
   end
   // ----------------------------------------
   // Bus cycles and comparison
   // ----------------------------------------
   task chk(input logic [23:0] g, input logic [23:0] e);
      num_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Strobes stay up between calls, so back-to-back writes never toggle them
   task acc(input logic w, r, k, input logic [3:0] a, input logic [7:0] d);
      i_wr = w;
      i_rd = r;
      i_unlock_key = k;
      i_addr = a;
      i_wdata = d;
      @(negedge I_CLK_SYS);
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      acc(1'b0, 1'b1, 1'b0, a, 8'h00);
      chk(o_rdata, e);
   endtask
   task launches(input logic [23:0] e);
      n = 24'h0;
      repeat (6)
      begin
         if (o_launch === 1'b1)
            n++;
         acc(1'b0, 1'b0, 1'b0, 4'h0, 8'h00);
      end
      chk(n, e);
   endtask
   task finish_op;
      i_op_done = 1'b1;
      acc(1'b0, 1'b0, 1'b0, 4'h0, 8'h00);
      i_op_done = 1'b0;
      repeat (3)
         if (o_busy === 1'b1)
            acc(1'b0, 1'b0, 1'b0, 4'h0, 8'h00);
      chk(o_busy, 24'h0);
   endtask
   task wrap_up;
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      for (int i = 0; i < 10; i++)
         rd(ofs[i], 8'h00);
      acc(1'b1, 1'b0, 1'b0, OFS_PTR_LOW, 8'hA5);
      acc(1'b1, 1'b0, 1'b0, OFS_PTR_MID, 8'h3C);
      acc(1'b1, 1'b0, 1'b0, OFS_PTR_EXT, 8'h81);
      acc(1'b1, 1'b0, 1'b0, OFS_DATA_B0, 8'h12);
      acc(1'b1, 1'b0, 1'b0, OFS_DATA_B1, 8'h34);
      acc(1'b1, 1'b0, 1'b0, OFS_DATA_B2, 8'hC6);
      acc(1'b1, 1'b0, 1'b0, 4'h3, 8'hFF);
      acc(1'b1, 1'b0, 1'b0, OFS_OP_CODE, 8'hFF);
      chk(o_location, 24'h813CA5);
      chk(o_operand, 24'hC63412);
      chk(o_op_code, 24'h7F);
      rd(OFS_PTR_MID, 8'h3C);
      rd(OFS_DATA_B2, 8'hC6);
      rd(OFS_OP_CODE, 8'h7F);
      rd(4'h3, 8'h00);
   endtask
   task t_launch;
      acc(1'b1, 1'b0, 1'b0, OFS_LAUNCH, 8'h01);
      launches(24'h0);
      acc(1'b0, 1'b0, 1'b1, 4'h0, 8'h00);
      acc(1'b1, 1'b0, 1'b0, OFS_LAUNCH, 8'h00);
      launches(24'h0);
      acc(1'b0, 1'b0, 1'b1, 4'h0, 8'h00);
      acc(1'b1, 1'b0, 1'b0, OFS_LAUNCH, 8'h01);
      chk(o_launch, 24'h1);
      // A second strobe while the pulse stands must not stretch it
      acc(1'b1, 1'b0, 1'b0, OFS_LAUNCH, 8'h01);
      launches(24'h0);
      chk(o_busy, 24'h1);
      acc(1'b0, 1'b0, 1'b1, 4'h0, 8'h00);
      acc(1'b1, 1'b0, 1'b0, OFS_LAUNCH, 8'h01);
      launches(24'h0);
      rd(OFS_LAUNCH, 8'h00);
      rd(OFS_STATUS, 8'h80);
      finish_op;
   endtask
   // Last edge inside the unlock window is taken, the first one after it is not
   task t_window;
      acc(1'b0, 1'b0, 1'b1, 4'h0, 8'h00);
      repeat (3)
         acc(1'b0, 1'b0, 1'b0, 4'h0, 8'h00);
      acc(1'b1, 1'b0, 1'b0, OFS_LAUNCH, 8'h01);
      launches(24'h1);
      finish_op;
      acc(1'b0, 1'b0, 1'b1, 4'h0, 8'h00);
      repeat (4)
         acc(1'b0, 1'b0, 1'b0, 4'h0, 8'h00);
      acc(1'b1, 1'b0, 1'b0, OFS_LAUNCH, 8'h01);
      launches(24'h0);
   endtask
   // Enable low freezes the pointer and hides the unlock key
   task t_enable;
      i_ce = 1'b0;
      acc(1'b1, 1'b0, 1'b0, OFS_PTR_LOW, 8'h5A);
      acc(1'b0, 1'b0, 1'b1, 4'h0, 8'h00);
      i_ce = 1'b1;
      chk(o_location, 24'h813CA5);
      acc(1'b1, 1'b0, 1'b0, OFS_LAUNCH, 8'h01);
      launches(24'h0);
   endtask
   task t_result;
      i_result = 24'h5A0F96;
      i_result_valid = 1'b1;
      acc(1'b0, 1'b0, 1'b0, 4'h0, 8'h00);
      i_result_valid = 1'b0;
      rd(OFS_DATA_B1, 8'h0F);
      chk(o_operand, 24'h5A0F96);
   endtask
   initial
   begin
      I_RST_N = 1'b0;
      i_ce = 1'b1;
      i_op_done = 1'b0;
      i_result_valid = 1'b0;
      i_result = 24'h0;
      acc(1'b0, 1'b0, 1'b0, 4'h0, 8'h00);
      repeat (3) @(negedge I_CLK_SYS);
      I_RST_N = 1'b1;
      repeat (3) @(negedge I_CLK_SYS);
      t_regs;
      t_launch;
      t_window;
      t_enable;
      t_result;
      wrap_up;
   end
endmodule
